/* File: include/slil_map.svh */
// Purpose: Named constants for the status lamp driver.
// Assumes: 40 MHz mclk; 50 ms flash slot.
// Notes: Pattern timing is built from 50 ms slots.
`ifndef SLIL_MAP_SVH
`define SLIL_MAP_SVH
`define SLIL_CLK_HZ 40000000
`define SLIL_SLOT_MS 50
`define SLIL_SLOT_CYC ((`SLIL_CLK_HZ / 1000) * `SLIL_SLOT_MS)
`define SLIL_SLOT_W 21
`define SLIL_PH_W 5
`define SLIL_PH_LAST 5'h17
`define SLIL_FAST_MAX 3'h1
`define SLIL_BLK_MASK 5'h07
`define SLIL_ON_SLOTS 5'h04
`define SLIL_DBL_ON2 5'h08
`define SLIL_DBL_OFF2 5'h0C
`define SLIL_ERR_WRAP 5'h14
`define SLIL_ERR_LEAD 5'h04
`endif

/* File: include/slil_pkg.sv */
// Purpose: Types for the status lamp driver.
// Assumes: Slave state encoding is supplied by the fieldbus logic.
// Notes: Error patterns are listed from least to most severe.
package slil_pkg;
	typedef enum logic [1:0] {
		SLIL_ST_INIT = 2'h0,
		SLIL_ST_PREOP = 2'h1,
		SLIL_ST_SAFEOP = 2'h2,
		SLIL_ST_OP = 2'h3
	} slil_state_t;
	typedef enum {
		SLIL_PAT_OFF,
		SLIL_PAT_FLICKER,
		SLIL_PAT_BLINK,
		SLIL_PAT_SINGLE,
		SLIL_PAT_DOUBLE,
		SLIL_PAT_ON
	} slil_pat_t;
endpackage : slil_pkg

/* File: hw/slil_tick.sv */
// Purpose: Slot timebase, one pulse every 50 ms.
// Assumes: 40 MHz mclk.
// Notes: Enable pulse, not a derived clock.
`timescale 1ns/1ps
`include "slil_map.svh"
module slil_tick (
	input wire logic mclk,
	input wire logic rst,
	output logic slot_tick
);
	logic [`SLIL_SLOT_W-1:0] cnt_ff;
	logic [`SLIL_SLOT_W-1:0] nxt_cnt;
	wire cnt_end = (cnt_ff == `SLIL_SLOT_W'(`SLIL_SLOT_CYC - 1));
	assign nxt_cnt = cnt_end ? '0 : cnt_ff + `SLIL_SLOT_W'(1);
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_ff <= '0;
			slot_tick <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			slot_tick <= cnt_end;
		end
	end
endmodule : slil_tick

/* File: hw/slil_lamps.sv */
// Purpose: Status lamp driver for drive and fieldbus indicators.
// Assumes: Inputs come from logic on mclk; lamps are active high.
// Notes: 24 slots of 50 ms form a 1.2 s frame; run and error use
//        opposite halves of each blink period.
`timescale 1ns/1ps
`include "slil_map.svh"
module slil_lamps
	import slil_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic can_variant,
	input wire logic drive_error,
	input wire logic init_done,
	input wire logic setup_corrupt,
	input wire slil_state_t slave_state,
	input wire logic err_ctrl_fail,
	input wire logic err_watchdog,
	input wire logic err_local,
	input wire logic err_config,
	input wire logic err_boot,
	input wire logic port_in_link,
	input wire logic port_in_activity,
	input wire logic port_out_link,
	input wire logic port_out_activity,
	output logic drive_fault_lamp,
	output logic drive_ready_lamp,
	output logic fieldbus_run_lamp,
	output logic fieldbus_error_lamp,
	output logic port_in_link_activity_lamp,
	output logic port_out_link_activity_lamp,
	output logic al_status_error_ind
);
	////////////////////////////////////////////////////////////////
	// Timebase
	logic slot_tick;
	logic [`SLIL_PH_W-1:0] phase_ff;
	logic [`SLIL_PH_W-1:0] nxt_phase;
	logic [2:0] fast_ff;
	logic [2:0] nxt_fast;
	logic alt_ff;
	logic act_blink_ff;

	slil_tick u_tick (
		.mclk(mclk),
		.rst(rst),
		.slot_tick(slot_tick)
	);

	// Frame index wraps after the last of its 24 slots
	assign nxt_phase = (phase_ff == `SLIL_PH_LAST) ? '0 :
		phase_ff + `SLIL_PH_W'(1);
	assign nxt_fast = (fast_ff == `SLIL_FAST_MAX) ? '0 :
		fast_ff + 3'h1;

	// Alternation steps every second slot, activity toggle every slot
	always_ff @(posedge mclk) begin
		if (rst) begin
			phase_ff <= '0;
			fast_ff <= '0;
			alt_ff <= 1'b0;
			act_blink_ff <= 1'b0;
		end else if (slot_tick) begin
			phase_ff <= nxt_phase;
			fast_ff <= nxt_fast;
			if (fast_ff == `SLIL_FAST_MAX) begin
				alt_ff <= ~alt_ff;
			end
			act_blink_ff <= ~act_blink_ff;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pattern shapes; slot index counts 50 ms steps in the frame
	function automatic logic pat_level(input slil_pat_t pat,
		input logic [`SLIL_PH_W-1:0] ph, input logic flick);
		logic [`SLIL_PH_W-1:0] blk;
		blk = ph & `SLIL_BLK_MASK;
		case (pat)
			SLIL_PAT_OFF: pat_level = 1'b0;
			SLIL_PAT_ON: pat_level = 1'b1;
			// 200 ms on, 200 ms off, slots 0..3 of each 8
			SLIL_PAT_BLINK: pat_level = (blk < `SLIL_ON_SLOTS);
			// 200 ms on, 1000 ms off
			SLIL_PAT_SINGLE: pat_level = (ph < `SLIL_ON_SLOTS);
			// Two 200 ms pulses split by 200 ms, then 600 ms off
			SLIL_PAT_DOUBLE: pat_level = (ph < `SLIL_ON_SLOTS) ||
				((ph >= `SLIL_DBL_ON2) && (ph < `SLIL_DBL_OFF2));
			SLIL_PAT_FLICKER: pat_level = flick;
			default: pat_level = 1'b0;
		endcase
	endfunction : pat_level

	////////////////////////////////////////////////////////////////
	// Pattern selection
	logic [`SLIL_PH_W-1:0] err_phase;
	slil_pat_t run_pat;
	slil_pat_t err_pat;
	wire any_err = err_ctrl_fail | err_watchdog | err_local |
		err_config | err_boot;

	// Error frame leads by half a blink so the lit halves never meet
	assign err_phase = (phase_ff >= `SLIL_ERR_WRAP) ?
		phase_ff - `SLIL_ERR_WRAP : phase_ff + `SLIL_ERR_LEAD;

	// Run pattern follows the slave state alone
	always_comb begin
		case (slave_state)
			SLIL_ST_INIT: run_pat = SLIL_PAT_OFF;
			SLIL_ST_PREOP: run_pat = SLIL_PAT_BLINK;
			SLIL_ST_SAFEOP: run_pat = SLIL_PAT_SINGLE;
			SLIL_ST_OP: run_pat = SLIL_PAT_ON;
			default: run_pat = SLIL_PAT_OFF;
		endcase
	end

	always_comb begin
		// Priority chain, most severe first
		if (err_ctrl_fail) begin
			err_pat = SLIL_PAT_ON;
		end else if (err_watchdog) begin
			err_pat = SLIL_PAT_DOUBLE;
		end else if (err_local) begin
			err_pat = SLIL_PAT_SINGLE;
		end else if (err_config) begin
			err_pat = SLIL_PAT_BLINK;
		end else if (err_boot) begin
			err_pat = SLIL_PAT_FLICKER;
		end else begin
			err_pat = SLIL_PAT_OFF;
		end
	end

	wire run_lvl = pat_level(run_pat, phase_ff, fast_ff[0]);
	wire err_lvl = pat_level(err_pat, err_phase, fast_ff[0]);
	// Traffic blanks a linked lamp on every other slot
	wire ld_in = port_in_link & ~(port_in_activity & act_blink_ff);
	wire ld_out = port_out_link & ~(port_out_activity & act_blink_ff);

	////////////////////////////////////////////////////////////////
	// Next lamp levels
	logic nxt_fault;
	logic nxt_ready;
	logic nxt_run;
	logic nxt_err;
	logic nxt_in_lamp;
	logic nxt_out_lamp;
	logic nxt_err_ind;

	// Corrupt setup overrides: rapid alternation of ready and fault
	assign nxt_fault = setup_corrupt ? alt_ff : drive_error;
	assign nxt_ready = setup_corrupt ? ~alt_ff :
		(init_done & ~drive_error);
	// CAN-only builds leave every fieldbus lamp dark
	assign nxt_run = ~can_variant & run_lvl;
	// With no cause active the error lamp stays dark in any phase
	assign nxt_err = ~can_variant & any_err & err_lvl;
	assign nxt_in_lamp = ~can_variant & ld_in;
	assign nxt_out_lamp = ~can_variant & ld_out;
	// Indicator bit only while a local or booting error is shown
	assign nxt_err_ind = ~can_variant & ((err_pat == SLIL_PAT_SINGLE) |
		(err_pat == SLIL_PAT_FLICKER));

	////////////////////////////////////////////////////////////////
	// Registered outputs
	logic fault_ff;
	logic ready_ff;
	logic run_ff;
	logic err_ff;
	logic in_lamp_ff;
	logic out_lamp_ff;
	logic err_ind_ff;

	// Held in flip-flops so no decode glitch reaches a lamp
	always_ff @(posedge mclk) begin
		if (rst) begin
			fault_ff <= 1'b0;
			ready_ff <= 1'b0;
			run_ff <= 1'b0;
			err_ff <= 1'b0;
			in_lamp_ff <= 1'b0;
			out_lamp_ff <= 1'b0;
			err_ind_ff <= 1'b0;
		end else begin
			fault_ff <= nxt_fault;
			ready_ff <= nxt_ready;
			run_ff <= nxt_run;
			err_ff <= nxt_err;
			in_lamp_ff <= nxt_in_lamp;
			out_lamp_ff <= nxt_out_lamp;
			err_ind_ff <= nxt_err_ind;
		end
	end

	// Ports come straight from the flip-flops above
	assign drive_fault_lamp = fault_ff;
	assign drive_ready_lamp = ready_ff;
	assign fieldbus_run_lamp = run_ff;
	assign fieldbus_error_lamp = err_ff;
	assign port_in_link_activity_lamp = in_lamp_ff;
	assign port_out_link_activity_lamp = out_lamp_ff;
	assign al_status_error_ind = err_ind_ff;
endmodule : slil_lamps

/* File: tb/slil_lamps_props.sv */
// Purpose: Lamp checks at the driver ports.
// Assumes: Static lamps lag inputs by one edge.
// Notes: Slot patterns are too slow to check here.
`timescale 1ns/1ps
module slil_lamps_chk
	import slil_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic can_variant,
	input wire logic drive_error,
	input wire logic init_done,
	input wire logic setup_corrupt,
	input wire slil_state_t slave_state,
	input wire logic err_ctrl_fail,
	input wire logic port_in_link,
	input wire logic drive_fault_lamp,
	input wire logic drive_ready_lamp,
	input wire logic fieldbus_run_lamp,
	input wire logic fieldbus_error_lamp,
	input wire logic port_in_link_activity_lamp,
	input wire logic err_watchdog,
	input wire logic err_local,
	input wire logic err_config,
	input wire logic err_boot,
	input wire logic al_status_error_ind
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire rok = !rst && !can_variant;
	wire dok = !rst && !setup_corrupt;
	fault_tracks_a: assert property (
		$past(dok) |-> drive_fault_lamp == $past(drive_error))
		else $error("fault lamp wrong");
	ready_tracks_a: assert property (
		$past(dok) |-> drive_ready_lamp == $past(init_done && !drive_error))
		else $error("ready lamp wrong");
	link_dark_a: assert property (
		$past(!rst && !port_in_link) |-> !port_in_link_activity_lamp)
		else $error("link lamp lit");
	can_quiet_a: assert property ($past(!rst && can_variant) |->
		!(fieldbus_run_lamp || fieldbus_error_lamp))
		else $error("can lamps lit");
	run_init_a: assert property (
		$past(rok && slave_state == SLIL_ST_INIT) |-> !fieldbus_run_lamp)
		else $error("run lit in init");
	run_steady_a: assert property (
		$past(rok && slave_state == SLIL_ST_OP) |-> fieldbus_run_lamp)
		else $error("run dark in op");
	err_steady_a: assert property (
		$past(rok && err_ctrl_fail) |-> fieldbus_error_lamp)
		else $error("error lamp dark");
	setup_alt_a: assert property (
		$past(!rst && setup_corrupt) |-> drive_fault_lamp != drive_ready_lamp)
		else $error("lamps not alternate");
	wire no_err = !err_ctrl_fail && !err_watchdog && !err_local &&
		!err_config && !err_boot;
	err_quiet_a: assert property ($past(rok && no_err) |->
		!fieldbus_error_lamp)
		else $error("error lamp lit");
	ind_can_a: assert property ($past(!rst && can_variant) |->
		!al_status_error_ind && !port_in_link_activity_lamp)
		else $error("can indicator set");
	ind_local_a: assert property (
		$past(rok && err_local && !err_ctrl_fail && !err_watchdog) |->
		al_status_error_ind)
		else $error("indicator bit clear");
endmodule : slil_lamps_chk
bind slil_lamps slil_lamps_chk chk_u (.*);

/* File: tb/slil_panel.sv */
// Purpose: Operator looking at the lamp panel.
// Assumes: Lamps are active high.
// Notes: An eye sees levels only, no history.
`timescale 1ns/1ps
module slil_panel (
	input wire logic [6:0] lamps,
	output logic [6:0] view
);
	assign view = lamps;
endmodule : slil_panel

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the lamp driver.
// Assumes: Frame phase stays at slot 0 all run.
// Notes: A 50 ms slot is far longer than this run.
`timescale 1ns/1ps
module tb_top;
	import slil_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] in_v = 16'h0000;
	wire [6:0] o;
	logic [6:0] view;
	int failures = 0;
	int tests_run = 0;
	always #12.5 mclk = ~mclk;
	slil_lamps dut_u (.mclk(mclk), .rst(rst), .can_variant(in_v[15]),
		.drive_error(in_v[14]), .init_done(in_v[13]),
		.setup_corrupt(in_v[12]), .slave_state(slil_state_t'(in_v[11:10])),
		.err_ctrl_fail(in_v[9]), .err_watchdog(in_v[8]), .err_local(in_v[7]),
		.err_config(in_v[6]), .err_boot(in_v[5]), .port_in_link(in_v[4]),
		.port_in_activity(in_v[3]), .port_out_link(in_v[2]),
		.port_out_activity(in_v[1]), .drive_fault_lamp(o[6]),
		.drive_ready_lamp(o[5]), .fieldbus_run_lamp(o[4]),
		.fieldbus_error_lamp(o[3]), .port_in_link_activity_lamp(o[2]),
		.port_out_link_activity_lamp(o[1]), .al_status_error_ind(o[0]));
	slil_panel pnl_u (.lamps(o), .view(view));
	task automatic check(input logic [6:0] got, input logic [6:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: lamps %h not %h", $time, got, exp);
		end
	endtask : check
	task automatic go(input logic [15:0] v, input logic [6:0] e);
		@(posedge mclk) in_v <= v;
		repeat (2) @(posedge mclk);
		#1 check(view, e);
	endtask : go
	task automatic t_drive;
		go(16'h2C00, 7'h30);
		go(16'h6C00, 7'h50);
		go(16'h0000, 7'h00);
		go(16'h2400, 7'h30);
		go(16'h2440, 7'h30);
		go(16'h2800, 7'h30);
		$display("t_drive done");
	endtask : t_drive
	task automatic t_err;
		go(16'h2200, 7'h28);
		go(16'h2100, 7'h20);
		go(16'h2080, 7'h21);
		go(16'h2040, 7'h20);
		go(16'h2020, 7'h21);
		go(16'h2340, 7'h28);
		go(16'h2180, 7'h20);
		go(16'h2000, 7'h20);
		$display("t_err done");
	endtask : t_err
	task automatic t_misc;
		go(16'h2018, 7'h24);
		go(16'h2004, 7'h22);
		go(16'hAE94, 7'h20);
		go(16'h7000, 7'h20);
		$display("t_misc done");
	endtask : t_misc
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		#1 check(view, 7'h00);
		t_drive();
		t_err();
		t_misc();
		end_sim();
	end
	// About 19 checks of 3 cycles each need far less than this
	initial begin
		#100000;
		failures++;
		end_sim();
	end
endmodule : tb_top
